// ### verilog/lane_err_params.svh
// constants of the lane error counter control block
// assumes: included by bare name by the package user files
`ifndef LANE_ERR_PARAMS_SVH
`define LANE_ERR_PARAMS_SVH

// register addresses, one byte register per lane, consecutive
`define LANE_ADDR_W     12
`define LANE5_ADDR      12'h485
`define LANE6_ADDR      12'h486
`define LANE7_ADDR      12'h487

// lanes handled here: 5, 6 and 7
`define FIRST_LANE      5
`define NUM_LANES       3

// field positions inside each lane register
`define ENABLE_MSB      5
`define ENABLE_LSB      3
`define CLEAR_MSB       2
`define CLEAR_LSB       0
`define RESERVED_MSB    7
`define RESERVED_LSB    6

// reset values of the fields
`define ENABLE_RESET    3'h7
`define CLEAR_RESET     3'h7

`endif

// ### verilog/lane_err_pkg.sv
// types of the lane error counter control block
// assumes: nothing beyond the params header
`default_nettype none

package lane_err_pkg;

  // one bit per decode error kind; order fixes the field bit positions
  typedef struct packed {
    logic ctrl_char;     // bit 2: unexpected control character
    logic missing_code;  // bit 1: code missing from table
    logic disparity;     // bit 0: running disparity error
  } err_code_type;

  // control fields of one lane
  typedef struct packed {
    err_code_type enable;
    err_code_type clear;
  } lane_ctrl_type;

  // state of the top module
  typedef struct packed {
    logic [7:0]             rdata;
    logic                   rvalid;
    err_code_type [2:0]     inc;
  } top_state_type;

endpackage

`default_nettype wire

// ### verilog/lane_ctrl_reg.sv
// one lane counter control register: enable and clear fields
// assumes: write select already decoded, same clock as the register port
`timescale 1ns/10ps
`default_nettype none
`include "lane_err_params.svh"

module lane_ctrl_reg
(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // register write
  input  wire logic                    wr_sel,
  input  wire logic [7:0]              wdata,
  // held control fields
  output var  lane_err_pkg::lane_ctrl_type ctrl
);

  lane_err_pkg::lane_ctrl_type ctrl_r;
  lane_err_pkg::lane_ctrl_type ctrl_nxt;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    // reserved bits 7:6 of wdata are never stored, so they cannot read back
    if (wr_sel)
    begin
      ctrl_nxt.enable = wdata[`ENABLE_MSB:`ENABLE_LSB];
      ctrl_nxt.clear  = wdata[`CLEAR_MSB:`CLEAR_LSB];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_r.enable <= `ENABLE_RESET;
      ctrl_r.clear  <= `CLEAR_RESET;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign ctrl = ctrl_r;

endmodule

`default_nettype wire

// ### verilog/lane_err_ctrl.sv
// control of the decode error counters of lanes 5, 6 and 7
// assumes: decoder strobes and register port are on mclk; the
// counters themselves sit outside and obey count_inc / count_clear
//
// Behaviour
// - lanes 5-7: enable field bits 5:3
// - lanes 5-7: clear field bits 2:0, holds
// - bit2 control char, bit1 table, bit0 disparity
// - enable field resets to all ones
// - clear field resets to all ones
// - lane 6 and 7 at consecutive byte addresses
`timescale 1ns/10ps
`default_nettype none
`include "lane_err_params.svh"

module lane_err_ctrl
(
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // register port
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [`LANE_ADDR_W-1:0]     reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output var  logic [7:0]                  reg_rdata,
  output var  logic                        reg_rvalid,
  // decoder error strobes, index 0 is lane 5
  input  wire lane_err_pkg::err_code_type [2:0] err_strobe,
  // counter controls, index 0 is lane 5
  output var  lane_err_pkg::err_code_type [2:0] count_inc,
  output var  lane_err_pkg::err_code_type [2:0] count_enable,
  output var  lane_err_pkg::err_code_type [2:0] count_clear
);

  ////////////////////////////////////////////////////////////////////
  // per lane registers and decode

  lane_err_pkg::lane_ctrl_type   ctrl [`NUM_LANES];
  logic [`NUM_LANES-1:0]         hit;
  logic [7:0]                    word [`NUM_LANES];
  lane_err_pkg::err_code_type    inc_nxt [`NUM_LANES];

  genvar g;
  generate
    for (g = 0; g < `NUM_LANES; g++)
    begin : lane
      localparam logic [`LANE_ADDR_W-1:0] LANE_ADDR = `LANE5_ADDR + `LANE_ADDR_W'(g);

      assign hit[g] = (reg_addr == LANE_ADDR);

      lane_ctrl_reg u_reg
      (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .wr_sel (reg_wr && hit[g]),
        .wdata  (reg_wdata),
        .ctrl   (ctrl[g])
      );

      // reserved bits read back as zero
      assign word[g] = {2'h0, ctrl[g].enable, ctrl[g].clear};

      // a held clear wins over enable: a counter in reset never counts
      assign inc_nxt[g] = err_strobe[g] & ctrl[g].enable & ~ctrl[g].clear;

      assign count_enable[g] = ctrl[g].enable;
      assign count_clear[g]  = ctrl[g].clear;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // read back and strobe gating

  lane_err_pkg::top_state_type st_r;
  lane_err_pkg::top_state_type st_nxt;

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = reg_rd;
    // unmapped addresses answer zero, so the port never hangs
    st_nxt.rdata  = 8'h00;
    for (int i = 0; i < `NUM_LANES; i++)
    begin
      if (reg_rd && hit[i])
      begin
        st_nxt.rdata = word[i];
      end
      st_nxt.inc[i] = inc_nxt[i];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata  = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign count_inc  = st_r.inc;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking

  // every check samples on the rising edge only; the strobes and the register
  // port are launched on the same clock, so no settling window is needed.
  // the reset checks below switch the default disable off on purpose,
  // since they look at what reset itself leaves behind
  default disable iff (!rst_n);

  genvar b;
  generate
    for (g = 0; g < `NUM_LANES; g++)
    begin : chk_lane
      for (b = 0; b < 3; b++)
      begin : chk_bit
        a_disabled_no_count : assert property (
          (!count_enable[g][b] || count_clear[g][b]) |=> !count_inc[g][b])
          else $error("counter strobe passed while disabled or cleared");

        a_clear_holds : assert property (
          (count_clear[g][b] && !reg_wr) |=> count_clear[g][b] && !count_inc[g][b])
          else $error("clear field bit dropped without a write");

        a_strobe_passes : assert property (
          (err_strobe[g][b] && count_enable[g][b] && !count_clear[g][b]) |=> count_inc[g][b])
          else $error("enabled error strobe was not passed on");
      end

      a_enable_after_reset : assert property (
        @(posedge mclk) disable iff (1'b0)
        (!rst_n) |=> (count_enable[g] == `ENABLE_RESET))
        else $error("enable field not all ones after reset");

      a_clear_after_reset : assert property (
        @(posedge mclk) disable iff (1'b0)
        (!rst_n ##1 rst_n && !$past(reg_wr)) |-> (count_clear[g] == `CLEAR_RESET))
        else $error("clear field not all ones after reset");

      a_inc_after_reset : assert property (
        @(posedge mclk) disable iff (1'b0)
        (!rst_n) |=> (count_inc[g] == '0))
        else $error("counter strobe seen straight after reset");

      // the address comes from the map itself, not from the decode above
      a_write_lands : assert property (
        (reg_wr && reg_addr == `LANE_ADDR_W'(`LANE5_ADDR + g))
          |=> count_enable[g] == $past(reg_wdata[`ENABLE_MSB:`ENABLE_LSB])
           && count_clear[g]  == $past(reg_wdata[`CLEAR_MSB:`CLEAR_LSB]))
        else $error("write did not land in the addressed lane");

      // a read in the same cycle as a write answers the old value
      a_lane_readback : assert property (
        (reg_rd && reg_addr == `LANE_ADDR_W'(`LANE5_ADDR + g))
          |=> reg_rvalid && reg_rdata == {2'h0, $past(count_enable[g]), $past(count_clear[g])})
        else $error("lane read back did not show the held fields");

      a_fields_hold : assert property (
        !reg_wr |=> $stable(count_enable[g]) && $stable(count_clear[g]))
        else $error("lane fields changed without a write");
    end
  endgenerate

  a_field_order : assert property (
    (reg_wr && reg_addr == `LANE6_ADDR)
      |=> count_enable[1].ctrl_char    == $past(reg_wdata[5])
       && count_enable[1].missing_code == $past(reg_wdata[4])
       && count_enable[1].disparity    == $past(reg_wdata[3])
       && count_clear[1].ctrl_char     == $past(reg_wdata[2])
       && count_clear[1].missing_code  == $past(reg_wdata[1])
       && count_clear[1].disparity     == $past(reg_wdata[0]))
    else $error("lane 6 field bits landed in the wrong counter");

  a_lane7_address : assert property (
    (reg_wr && reg_addr == `LANE7_ADDR)
      |=> count_enable[2] == $past(reg_wdata[5:3])
       && count_clear[2]  == $past(reg_wdata[2:0])
       && $stable(count_enable[1]) && $stable(count_clear[1]))
    else $error("lane 7 write missed its register or hit lane 6");

  a_lane6_readback : assert property (
    (reg_rd && !reg_wr && reg_addr == `LANE6_ADDR)
      |=> reg_rvalid && reg_rdata[5:0] == {count_enable[1], count_clear[1]})
    else $error("lane 6 read back wrong value");

  a_reserved_zero : assert property (
    reg_rvalid |-> reg_rdata[`RESERVED_MSB:`RESERVED_LSB] == 2'h0)
    else $error("reserved bits read non zero");

  a_read_one_cycle : assert property (
    reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read answer not exactly one cycle later");

  ////////////////////////////////////////////////////////////////////
  // address map edges and idle port

  // unmapped reads must still answer, or a polling master would hang
  a_unmapped_zero : assert property (
    (reg_rd && (reg_addr < `LANE5_ADDR || reg_addr > `LANE7_ADDR))
      |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped address read back non zero");

  a_idle_quiet : assert property (
    !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read answer without a read request");

  a_lane5_isolated : assert property (
    (reg_wr && reg_addr == `LANE5_ADDR)
      |=> $stable(count_enable[1]) && $stable(count_clear[1])
       && $stable(count_enable[2]) && $stable(count_clear[2]))
    else $error("lane 5 write disturbed lane 6 or 7");

endmodule

`default_nettype wire

// ### tb/lane_tx_model.sv
// stand-in for the link transmitter as seen through the lane decoders
// assumes: bench calls send at the falling edge of mclk
`timescale 1ns/10ps
`default_nettype none

module lane_tx_model
(
  // clock
  input  wire logic                             mclk,
  // decoder error strobes into the block
  output var  lane_err_pkg::err_code_type [2:0] err_strobe
);
  initial err_strobe = '0;

  // whole vector set once a step, so back-to-back sends never double drive
  task automatic send(input int lane, input logic [2:0] code);
    lane_err_pkg::err_code_type [2:0] v;
    begin
      v = '0;
      v[lane] = code;
      err_strobe = v;
      @(negedge mclk);
    end
  endtask
endmodule

`default_nettype wire

// ### tb/lane_err_ctrl_tb.sv
// bench of the lane error counter control block
// assumes: package, design and transmitter model compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "lane_err_params.svh"

module lane_err_ctrl_tb;
  logic                             mclk = 1'b0;
  logic                             rst_n = 1'b0;
  logic                             reg_wr = 1'b0;
  logic                             reg_rd = 1'b0;
  logic [`LANE_ADDR_W-1:0]          reg_addr = '0;
  logic [7:0]                       reg_wdata = 8'h00;
  logic [7:0]                       reg_rdata;
  logic                             reg_rvalid;
  lane_err_pkg::err_code_type [2:0] err_strobe;
  lane_err_pkg::err_code_type [2:0] count_inc;
  lane_err_pkg::err_code_type [2:0] count_enable;
  lane_err_pkg::err_code_type [2:0] count_clear;
  int                               fail_count = 0;
  int                               n_checks = 0;

  always #50 mclk = ~mclk;

  lane_err_ctrl i_lane_err_ctrl (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .err_strobe(err_strobe), .count_inc(count_inc),
    .count_enable(count_enable), .count_clear(count_clear));
  lane_tx_model i_lane_tx_model (.mclk(mclk), .err_strobe(err_strobe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        fail_count++;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // one cycle on the register port; requests stay up when calls follow back to back
  task automatic xfer(input logic w, input logic r, input logic [11:0] a,
                      input logic [7:0] d, input logic [7:0] e);
    begin
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      chk({7'h00, reg_rvalid}, {7'h00, r});
      if (r)
        chk(reg_rdata, e);
    end
  endtask

  task automatic strobe(input int lane, input logic [2:0] code, input logic [2:0] e);
    begin
      i_lane_tx_model.send(lane, code);
      chk({5'h00, count_inc[lane]}, {5'h00, e});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      chk({5'h00, count_enable[i]}, 8'h07);
      chk({5'h00, count_clear[i]}, 8'h07);
      xfer(1'b0, 1'b1, 12'h485 + 12'(i), 8'h00, 8'h3f);
      strobe(i, 3'h7, 3'h0);
    end
    xfer(1'b1, 1'b0, 12'h486, 8'hc5, 8'h00);
    xfer(1'b0, 1'b1, 12'h486, 8'h00, 8'h05);
    chk({5'h00, count_enable[1]}, 8'h00);
    chk({5'h00, count_clear[1]}, 8'h05);
    xfer(1'b1, 1'b0, 12'h487, 8'h38, 8'h00);
    xfer(1'b0, 1'b1, 12'h487, 8'h00, 8'h38);
    xfer(1'b0, 1'b1, 12'h488, 8'h00, 8'h00);
    xfer(1'b1, 1'b1, 12'h487, 8'h3f, 8'h38);
    xfer(1'b1, 1'b0, 12'h487, 8'h38, 8'h00);
    xfer(1'b1, 1'b0, 12'h485, 8'h3b, 8'h00);
    xfer(1'b0, 1'b1, 12'h485, 8'h00, 8'h3b);
    xfer(1'b0, 1'b0, 12'h000, 8'h00, 8'h00);
    // one error kind at a time shows each bit lands on its own counter
    for (int b = 0; b < 3; b++)
      strobe(2, 3'h1 << b, 3'h1 << b);
    strobe(1, 3'h7, 3'h0);
    strobe(0, 3'h7, 3'h4);
    strobe(2, 3'h0, 3'h0);
    // a second reset mid-run brings every field back
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      chk({5'h00, count_enable[i]}, 8'h07);
      chk({5'h00, count_clear[i]}, 8'h07);
      chk({5'h00, count_inc[i]}, 8'h00);
    end
    conclude;
  end

  // the whole sequence needs under 40 cycles
  initial
  begin
    #100000;
    fail_count++;
    conclude;
  end
endmodule

`default_nettype wire
